// ==== pss_assertions.sv ====
// Checker that watches the ports of the summary status register.
`timescale 1ns/1ps
module pss_chk
  import pss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic mgmt_rd_strobe,
  input wire logic [4:0] mgmt_rd_addr,
  input wire logic crossover_auto_enable,
  input wire logic crossover_force,
  input wire logic pair_swap_async,
  input wire logic signal_detect_raw,
  input wire logic descrambler_lock_async,
  input wire logic polarity_inverted_async,
  input wire logic qualify_enable,
  input wire logic rx_error_event,
  input wire logic false_carrier_event,
  input wire logic page_received_event,
  input wire logic interrupt_event,
  input wire logic remote_fault_event,
  input wire logic link_up,
  input wire logic speed_10,
  input wire logic full_duplex,
  input wire logic autoneg_done,
  input wire logic loopback_on,
  input wire logic jabber_seen,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Decoded reads that the properties refer to.
  wire logic sum_rd = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_SUMMARY);
  wire logic fc_rd = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_FALSE_CARRIER);
  property p_answer; sum_rd |=> rd_valid; endproperty
  property p_refuse; !sum_rd |=> !rd_valid; endproperty
  property p_top; rd_valid |-> !rd_data[BIT_RESERVED]; endproperty
  property p_hold; !rd_valid |-> $stable(rd_data); endproperty
  property p_levels;
    sum_rd |=> rd_data[5:0] == $past({jabber_seen, autoneg_done, loopback_on, full_duplex,
      speed_10, link_up});
  endproperty
  property p_force; crossover_force [*3] ##0 sum_rd |=> rd_data[BIT_XOVER]; endproperty
  property p_rx; rx_error_event ##1 !mgmt_rd_strobe ##1 sum_rd |=> rd_data[BIT_RX_ERROR];
  endproperty
  property p_int; interrupt_event ##1 !mgmt_rd_strobe ##1 sum_rd |=> rd_data[BIT_INT_PENDING];
  endproperty
  property p_fc_clr;
    (fc_rd && !false_carrier_event) ##1 (!mgmt_rd_strobe && !false_carrier_event)
      ##1 (sum_rd && !false_carrier_event) |=> !rd_data[BIT_FALSE_CARRIER];
  endproperty
  a_answer: assert property (p_answer) else $error("summary read got no answer");
  a_refuse: assert property (p_refuse) else $error("answer without summary read");
  a_top: assert property (p_top) else $error("reserved bit read as one");
  a_hold: assert property (p_hold) else $error("read word changed between reads");
  a_levels: assert property (p_levels) else $error("level bits wrong");
  a_force: assert property (p_force) else $error("forced crossover not shown");
  a_rx: assert property (p_rx) else $error("receive error latch not set");
  a_int: assert property (p_int) else $error("interrupt pending not set");
  a_fc_clr: assert property (p_fc_clr) else $error("false carrier not cleared");
  c_sum: cover property (sum_rd);
  c_force: cover property (crossover_force [*3] ##0 sum_rd);
  c_rx: cover property (rx_error_event ##1 !mgmt_rd_strobe ##1 sum_rd);
endmodule : pss_chk

// ==== pss_flag.sv ====
// Sticky status flag that latches to a chosen level and is released by a clear request.
`timescale 1ns/1ps
module pss_flag #(
  parameter logic LATCH_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic latch_event,
  input wire logic clear_req,
  output logic flag
);
  import pss_pkg::*;

  pss_flag_s st;
  pss_flag_s next_st;

  // A latching event in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    next_st = st;
    if (latch_event) begin
      next_st.q = LATCH_LEVEL;
    end else if (clear_req) begin
      next_st.q = ~LATCH_LEVEL;
    end
  end

  // State register; every flag reads zero after reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.q;

endmodule : pss_flag

// ==== pss_mgmt_model.sv ====
// Management controller model that issues register reads and takes the answer.
`timescale 1ns/1ps
module pss_mgmt_model (
  input wire logic clk_sys,
  output logic mgmt_rd_strobe,
  output logic [4:0] mgmt_rd_addr,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data
);
  // Bus starts idle.
  initial begin
    mgmt_rd_strobe = 1'b0;
    mgmt_rd_addr = 5'h00;
  end
  // One read: a one-cycle strobe, answer taken once the answering edge has passed.
  task automatic read(input logic [4:0] addr, output logic valid, output logic [15:0] data);
    @(negedge clk_sys);
    mgmt_rd_strobe = 1'b1;
    mgmt_rd_addr = addr;
    @(negedge clk_sys);
    valid = rd_valid;
    data = rd_data;
    mgmt_rd_strobe = 1'b0;
    mgmt_rd_addr = ~addr; // An idle address never repeats the last one.
  endtask : read
endmodule : pss_mgmt_model

// ==== pss_pkg.sv ====
// Package with the constants and state types of the summary status register block.
// Summary of operation
// RULE_01 - Top bit ignores writes and always reads zero.
// RULE_02 - Crossover bit follows auto enable and force; tracks pair swaps when auto only.
// RULE_03 - Crossover bit reads one for swapped pairs, zero for normal pairs.
// RULE_04 - Receive-error latch sets on a receive error since the last counter read.
// RULE_05 - Receive-error latch clears only on a read of the receive error counter.
// RULE_06 - Polarity bit mirrors the ten-megabit polarity flag; one means inverted.
// RULE_07 - Polarity bit clears on ten-megabit register read, not on summary read.
// RULE_08 - False-carrier latch sets on an event, clears on counter register read.
// RULE_09 - With qualify enabled, signal detect is raw detect AND descrambler lock.
// RULE_10 - With qualify disabled, signal detect equals raw detect; the bit latches low.
// RULE_11 - Descrambler lock is reported in its own latched-low bit.
// RULE_12 - Page-received bit mirrors the expansion flag; summary read leaves it.
// RULE_13 - Page-received sets on a new page, clears on expansion register read.
// RULE_14 - Interrupt-pending bit reads one while an internal interrupt is pending.
// RULE_15 - Interrupt status register read clears the pending interrupt bit.
// RULE_16 - Remote fault bit sets when the partner signals a remote fault.
// RULE_17 - Remote fault clears on basic status read or reset, not summary read.
// RULE_18 - Link bit mirrors the basic link flag and is not cleared by summary read.
// RULE_19 - Speed bit reads one for 10 Mb/s and zero for 100 Mb/s.
// RULE_20 - Duplex bit reads one for full duplex and zero for half duplex.
// RULE_21 - Auto-negotiation complete bit reads one once negotiation has finished.
// RULE_22 - One read returns a coherent snapshot and clears no source flag.
package pss_pkg;

  // Management register addresses that this block decodes.
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_AN_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_SUMMARY = 5'h10;
  localparam logic [4:0] ADDR_INT_STATUS = 5'h12;
  localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h14;
  localparam logic [4:0] ADDR_RX_ERROR = 5'h15;
  localparam logic [4:0] ADDR_TENBASE = 5'h1A;

  // Bit positions inside the summary word.
  localparam int BIT_LINK = 0;
  localparam int BIT_SPEED10 = 1;
  localparam int BIT_DUPLEX = 2;
  localparam int BIT_LOOPBACK = 3;
  localparam int BIT_AN_DONE = 4;
  localparam int BIT_JABBER = 5;
  localparam int BIT_REMOTE_FAULT = 6;
  localparam int BIT_INT_PENDING = 7;
  localparam int BIT_PAGE_RX = 8;
  localparam int BIT_LOCK = 9;
  localparam int BIT_SIG_DETECT = 10;
  localparam int BIT_FALSE_CARRIER = 11;
  localparam int BIT_POLARITY = 12;
  localparam int BIT_RX_ERROR = 13;
  localparam int BIT_XOVER = 14;
  localparam int BIT_RESERVED = 15;

  // Index of each sticky flag in the flag bank.
  localparam int FLAG_RX_ERROR = 0;
  localparam int FLAG_FALSE_CARRIER = 1;
  localparam int FLAG_POLARITY = 2;
  localparam int FLAG_PAGE_RX = 3;
  localparam int FLAG_INT_PENDING = 4;
  localparam int FLAG_REMOTE_FAULT = 5;
  localparam int FLAG_SIG_DETECT = 6;
  localparam int FLAG_LOCK = 7;
  localparam int NUM_FLAGS = 8;
  // Level each flag latches to: ones latch high, zeros latch low.
  localparam logic [7:0] FLAG_LATCH_LEVEL = 8'h3F;

  // Index of each pin input in the synchroniser bank.
  localparam int PIN_PAIR_SWAP = 0;
  localparam int PIN_SIG_DETECT = 1;
  localparam int PIN_LOCK = 2;
  localparam int PIN_POLARITY = 3;
  localparam int NUM_PINS = 4;

  // Reset values.
  localparam logic [15:0] RST_SUMMARY = 16'h0000;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic q;
  } pss_sync_s;

  typedef struct packed {
    logic q;
  } pss_flag_s;

  typedef struct packed {
    logic [15:0] rd_data;
    logic rd_valid;
    logic xover;
  } pss_main_s;

endpackage : pss_pkg

// ==== pss_summary_status.sv ====
// Summary status register that gathers link state and sticky flags into one word.
`timescale 1ns/1ps
module pss_summary_status (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Management read port.
  input wire logic mgmt_rd_strobe,
  input wire logic [4:0] mgmt_rd_addr,
  // Crossover control and status.
  input wire logic crossover_auto_enable,
  input wire logic crossover_force,
  input wire logic pair_swap_async,
  // Receive path status from the medium side.
  input wire logic signal_detect_raw,
  input wire logic descrambler_lock_async,
  input wire logic polarity_inverted_async,
  input wire logic qualify_enable,
  // Event pulses from logic on this clock.
  input wire logic rx_error_event,
  input wire logic false_carrier_event,
  input wire logic page_received_event,
  input wire logic interrupt_event,
  input wire logic remote_fault_event,
  // Level status from logic on this clock.
  input wire logic link_up,
  input wire logic speed_10,
  input wire logic full_duplex,
  input wire logic autoneg_done,
  input wire logic loopback_on,
  input wire logic jabber_seen,
  // Read answer.
  output logic [15:0] rd_data,
  output logic rd_valid
);
  import pss_pkg::*;

  pss_main_s st;
  pss_main_s next_st;

  // Raw pin inputs gathered for the synchroniser bank.
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_sync;

  // Per-flag latch events, clear requests and current values.
  logic [NUM_FLAGS-1:0] flag_event;
  logic [NUM_FLAGS-1:0] flag_clear;
  logic [NUM_FLAGS-1:0] flag_q;

  // Read decode terms.
  logic rd_summary;
  logic rd_basic_status;
  logic rd_an_expansion;
  logic rd_int_status;
  logic rd_false_carrier;
  logic rd_rx_error;
  logic rd_tenbase;

  // Derived status.
  logic sd_qualified;
  logic xover_value;
  logic [15:0] summary_word;

  // Pins from the medium side arrive from another clock domain.
  assign pin_raw[PIN_PAIR_SWAP] = pair_swap_async;
  assign pin_raw[PIN_SIG_DETECT] = signal_detect_raw;
  assign pin_raw[PIN_LOCK] = descrambler_lock_async;
  assign pin_raw[PIN_POLARITY] = polarity_inverted_async;

  // One synchroniser per pin input.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp = gp + 1) begin : g_pin
      pss_sync3 u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(pin_raw[gp]),
        .sync_out(pin_sync[gp])
      );
    end
  endgenerate

  // Decode of every management read that has a side effect here.
  always_comb begin
    rd_summary = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_SUMMARY);
    rd_basic_status = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_BASIC_STATUS);
    rd_an_expansion = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_AN_EXPANSION);
    rd_int_status = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_INT_STATUS);
    rd_false_carrier = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_FALSE_CARRIER);
    rd_rx_error = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_RX_ERROR);
    rd_tenbase = mgmt_rd_strobe && (mgmt_rd_addr == ADDR_TENBASE);
  end

  // Qualified signal detect, optionally gated by descrambler lock.
  always_comb begin
    if (qualify_enable) begin
      sd_qualified = pin_sync[PIN_SIG_DETECT] & pin_sync[PIN_LOCK]; // see RULE_09
    end else begin
      sd_qualified = pin_sync[PIN_SIG_DETECT]; // see RULE_10
    end
  end

  // Latch events of the sticky flags.
  always_comb begin
    flag_event = '0;
    // Receive errors are remembered until the error counter is read.
    flag_event[FLAG_RX_ERROR] = rx_error_event; // see RULE_04
    // False carrier events are remembered until the carrier counter is read.
    flag_event[FLAG_FALSE_CARRIER] = false_carrier_event; // see RULE_08
    // Inverted polarity is held like the ten-megabit copy of the flag.
    flag_event[FLAG_POLARITY] = pin_sync[PIN_POLARITY]; // see RULE_06
    // A new link code word sets the page flag.
    flag_event[FLAG_PAGE_RX] = page_received_event; // see RULE_12, RULE_13
    // An internal interrupt leaves the pending flag set.
    flag_event[FLAG_INT_PENDING] = interrupt_event; // see RULE_14
    // A remote fault signalled by the partner is held.
    flag_event[FLAG_REMOTE_FAULT] = remote_fault_event; // see RULE_16
    // Loss of qualified detect pulls its bit low and holds it there.
    flag_event[FLAG_SIG_DETECT] = ~sd_qualified; // see RULE_10
    // Loss of descrambler lock pulls its bit low and holds it there.
    flag_event[FLAG_LOCK] = ~pin_sync[PIN_LOCK]; // see RULE_11
  end

  // Clear requests come only from reads of the owning registers, never the summary.
  always_comb begin
    flag_clear = '0;
    flag_clear[FLAG_RX_ERROR] = rd_rx_error; // see RULE_05
    flag_clear[FLAG_FALSE_CARRIER] = rd_false_carrier; // see RULE_08
    flag_clear[FLAG_POLARITY] = rd_tenbase; // see RULE_07
    flag_clear[FLAG_PAGE_RX] = rd_an_expansion; // see RULE_13
    flag_clear[FLAG_INT_PENDING] = rd_int_status; // see RULE_15
    flag_clear[FLAG_REMOTE_FAULT] = rd_basic_status; // see RULE_17
    // Latched-low bits are released by a basic status read while the source is good.
    flag_clear[FLAG_SIG_DETECT] = rd_basic_status;
    flag_clear[FLAG_LOCK] = rd_basic_status;
  end

  // One sticky flag per latched status bit.
  genvar gf;
  generate
    for (gf = 0; gf < NUM_FLAGS; gf = gf + 1) begin : g_flag
      pss_flag #(
        .LATCH_LEVEL(FLAG_LATCH_LEVEL[gf])
      ) u_flag (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .latch_event(flag_event[gf]),
        .clear_req(flag_clear[gf]),
        .flag(flag_q[gf])
      );
    end
  endgenerate

  // Crossover state from the enable and force settings and the swap detector.
  always_comb begin
    if (crossover_force) begin
      xover_value = 1'b1; // see RULE_02
    end else if (crossover_auto_enable) begin
      xover_value = pin_sync[PIN_PAIR_SWAP]; // see RULE_02, RULE_03
    end else begin
      xover_value = 1'b0; // see RULE_03
    end
  end

  // Assembly of the summary word from the current state of every source.
  always_comb begin
    summary_word = RST_SUMMARY;
    // The top bit has no storage and no write path.
    summary_word[BIT_RESERVED] = 1'b0; // see RULE_01
    summary_word[BIT_XOVER] = st.xover; // see RULE_03
    summary_word[BIT_RX_ERROR] = flag_q[FLAG_RX_ERROR]; // see RULE_04
    summary_word[BIT_POLARITY] = flag_q[FLAG_POLARITY]; // see RULE_06
    summary_word[BIT_FALSE_CARRIER] = flag_q[FLAG_FALSE_CARRIER]; // see RULE_08
    summary_word[BIT_SIG_DETECT] = flag_q[FLAG_SIG_DETECT]; // see RULE_10
    summary_word[BIT_LOCK] = flag_q[FLAG_LOCK]; // see RULE_11
    summary_word[BIT_PAGE_RX] = flag_q[FLAG_PAGE_RX]; // see RULE_12
    summary_word[BIT_INT_PENDING] = flag_q[FLAG_INT_PENDING]; // see RULE_14
    summary_word[BIT_REMOTE_FAULT] = flag_q[FLAG_REMOTE_FAULT]; // see RULE_16
    // Plain mirrors of level status.
    summary_word[BIT_JABBER] = jabber_seen;
    summary_word[BIT_AN_DONE] = autoneg_done; // see RULE_21
    summary_word[BIT_LOOPBACK] = loopback_on;
    summary_word[BIT_DUPLEX] = full_duplex; // see RULE_20
    summary_word[BIT_SPEED10] = speed_10; // see RULE_19
    summary_word[BIT_LINK] = link_up; // see RULE_18
  end

  // Next state: crossover tracking and the read snapshot.
  always_comb begin
    next_st = st;
    // The crossover bit follows its sources every cycle.
    next_st.xover = xover_value; // see RULE_02
    // The answer strobe lasts one cycle.
    next_st.rd_valid = 1'b0;
    if (rd_summary) begin
      // All sixteen bits are captured on the same edge; nothing is cleared.
      next_st.rd_data = summary_word; // see RULE_22
      next_st.rd_valid = 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st.rd_data <= RST_SUMMARY;
      st.rd_valid <= 1'b0;
      st.xover <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;

endmodule : pss_summary_status

// ==== pss_sync3.sv ====
// Three-stage synchroniser with an agreement filter for one pin input.
`timescale 1ns/1ps
module pss_sync3 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  import pss_pkg::*;

  pss_sync_s st;
  pss_sync_s next_st;

  // The first stage feeds only the second; the output moves once stages two and three agree.
  always_comb begin
    next_st = st;
    next_st.f1 = async_in;
    next_st.f2 = st.f1;
    next_st.f3 = st.f2;
    if (st.f2 == st.f3) begin
      next_st.q = st.f3;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.q;

endmodule : pss_sync3

// ==== pss_testbench.sv ====
// Self-checking testbench for the summary status register.
`timescale 1ns/1ps
module testbench;
  import pss_pkg::*;
  logic clk_sys, rst_n, xauto, xforce, swap, raw, lock, pol, qual, v, mgmt_rd_strobe, rd_valid;
  logic [4:0] ev, mgmt_rd_addr;
  logic [5:0] lv;
  logic [15:0] d, rd_data;
  int miscompares = 0;
  int tests_run = 0;
  int bit_of [5] = '{BIT_RX_ERROR, BIT_FALSE_CARRIER, BIT_PAGE_RX, BIT_INT_PENDING,
    BIT_REMOTE_FAULT};
  logic [4:0] clr_of [5] = '{ADDR_RX_ERROR, ADDR_FALSE_CARRIER, ADDR_AN_EXPANSION,
    ADDR_INT_STATUS, ADDR_BASIC_STATUS};
  pss_summary_status dut (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_rd_strobe(mgmt_rd_strobe),
    .mgmt_rd_addr(mgmt_rd_addr), .crossover_auto_enable(xauto), .crossover_force(xforce),
    .pair_swap_async(swap), .signal_detect_raw(raw), .descrambler_lock_async(lock),
    .polarity_inverted_async(pol), .qualify_enable(qual), .rx_error_event(ev[0]),
    .false_carrier_event(ev[1]), .page_received_event(ev[2]), .interrupt_event(ev[3]),
    .remote_fault_event(ev[4]), .link_up(lv[0]), .speed_10(lv[1]), .full_duplex(lv[2]),
    .loopback_on(lv[3]), .autoneg_done(lv[4]), .jabber_seen(lv[5]), .rd_data(rd_data),
    .rd_valid(rd_valid));
  pss_mgmt_model mgmt (.clk_sys(clk_sys), .mgmt_rd_strobe(mgmt_rd_strobe),
    .mgmt_rd_addr(mgmt_rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Expected word for the present levels with no sticky flag raised.
  function automatic logic [15:0] exp_word();
    logic [15:0] w;
    w = 16'h0000; // Reserved bit and quiet flags read zero.
    w[5:0] = lv;
    w[BIT_XOVER] = xforce | (xauto & swap);
    w[BIT_POLARITY] = pol;
    w[BIT_SIG_DETECT] = qual ? (raw & lock) : raw;
    w[BIT_LOCK] = lock;
    return w;
  endfunction : exp_word
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16
  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  // Watchdog against a hang.
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
  // Main sequence.
  initial begin
    {rst_n, xauto, xforce, swap, raw, lock, pol, qual, ev, lv} = '0;
    void'($urandom(39));
    idle(16);
    rst_n = 1'b1;
    mgmt.read(ADDR_SUMMARY, v, d);
    chk1("valid", 1'b1, v);
    chk16("reset word", 16'h0000, d);
    mgmt.read(5'h1F, v, d);
    chk1("unmapped", 1'b0, v);
    // Random levels and pins, read after settling and a release of the low latches.
    repeat (24) begin
      {xauto, xforce, swap, raw, lock, pol, qual} = 7'($urandom());
      lv = 6'($urandom());
      idle(6);
      mgmt.read(ADDR_TENBASE, v, d);
      chk1("refused", 1'b0, v);
      mgmt.read(ADDR_BASIC_STATUS, v, d);
      mgmt.read(ADDR_SUMMARY, v, d);
      chk16("word", exp_word(), d);
    end
    // Glitches: polarity latches high, lock and qualified detect latch low.
    {raw, lock, qual, pol} = 4'b1110;
    idle(6);
    mgmt.read(ADDR_BASIC_STATUS, v, d);
    {lock, pol} = 2'b01;
    idle(6);
    {lock, pol} = 2'b10;
    idle(6);
    mgmt.read(ADDR_SUMMARY, v, d);
    chk16("latched", 16'h1000, d & 16'h1600);
    // A second summary read must leave every latched bit where it was.
    mgmt.read(ADDR_SUMMARY, v, d);
    chk16("kept", 16'h1000, d & 16'h1600);
    mgmt.read(ADDR_TENBASE, v, d);
    mgmt.read(ADDR_BASIC_STATUS, v, d);
    mgmt.read(ADDR_SUMMARY, v, d);
    chk16("released", 16'h0600, d & 16'h1600);
    // Each of the five event-driven flags: set, kept across summary reads, cleared by its own register.
    for (int i = 0; i < 5; i++) begin
      ev[i] = 1'b1;
      idle(1);
      ev[i] = 1'b0;
      mgmt.read(ADDR_SUMMARY, v, d);
      chk1("flag set", 1'b1, d[bit_of[i]]);
      mgmt.read(ADDR_SUMMARY, v, d);
      chk1("flag kept", 1'b1, d[bit_of[i]]);
      mgmt.read(clr_of[i], v, d);
      mgmt.read(ADDR_SUMMARY, v, d);
      chk1("flag clear", 1'b0, d[bit_of[i]]);
    end
    // An event in the very cycle of its clearing read still leaves the flag set.
    fork
      mgmt.read(ADDR_RX_ERROR, v, d);
      begin
        @(negedge clk_sys);
        ev[0] = 1'b1;
        @(negedge clk_sys);
        ev[0] = 1'b0;
      end
    join
    mgmt.read(ADDR_SUMMARY, v, d);
    chk1("set beats clear", 1'b1, d[BIT_RX_ERROR]);
    // A reset in mid-run drops a pending remote fault.
    ev[4] = 1'b1;
    idle(1);
    {ev[4], rst_n} = 2'b00;
    idle(4);
    rst_n = 1'b1;
    mgmt.read(ADDR_SUMMARY, v, d);
    chk1("valid after reset", 1'b1, v);
    chk1("fault after reset", 1'b0, d[BIT_REMOTE_FAULT]);
    finish_test();
  end
endmodule : testbench
bind pss_summary_status pss_chk chk (.clk_sys, .rst_n, .mgmt_rd_strobe, .mgmt_rd_addr,
  .crossover_auto_enable, .crossover_force, .pair_swap_async, .signal_detect_raw,
  .descrambler_lock_async, .polarity_inverted_async, .qualify_enable, .rx_error_event,
  .false_carrier_event, .page_received_event, .interrupt_event, .remote_fault_event,
  .link_up, .speed_10, .full_duplex, .autoneg_done, .loopback_on, .jabber_seen,
  .rd_data, .rd_valid);
